/* File: hw/cpe_params.svh */
// register offsets, fields, reset values, preset matrices of the pixel path
`ifndef CPE_PARAMS_SVH
`define CPE_PARAMS_SVH
`define CPE_A_CTRL 6'h00
`define CPE_A_BAL0 6'h04
`define CPE_A_GAMMA 6'h10
`define CPE_A_STREN 6'h14
`define CPE_A_GAIN0 6'h18
`define CPE_A_GAIN8 6'h38
`define CPE_A_STAT 6'h3C
`define CPE_F_GEN 0
`define CPE_F_GUSER 1
`define CPE_F_DEPTH 3:2
`define CPE_F_LIGHT 6:4
`define CPE_D8 2'h0
`define CPE_D10 2'h1
`define CPE_D12 2'h2
`define CPE_FS8 12'h0FF
`define CPE_FS10 12'h3FF
`define CPE_FS12 12'hFFF
`define CPE_BAL_ONE 10'h040
`define CPE_BAL_FRAC 6
`define CPE_GAIN_ONE 9'h020
`define CPE_GAIN_FRAC 5
`define CPE_STREN_ONE 9'h100
`define CPE_STREN_FRAC 8
`define CPE_GAM_ONE 18'h10000
`define CPE_GAM_FRAC 16
`define CPE_GAM_SRGB 18'h0745D
`define CPE_MTX_DAY {9'h02C, 9'h1F8, 9'h1FC, 9'h1FA, 9'h02A, 9'h1FC, \
  9'h1FE, 9'h1F6, 9'h02C}
`define CPE_MTX_TUNG {9'h026, 9'h1FC, 9'h1FE, 9'h1FA, 9'h02C, 9'h1FA, \
  9'h1F6, 9'h1EA, 9'h040}
`define CPE_MTX_COOL {9'h02A, 9'h1FA, 9'h1FC, 9'h1FA, 9'h028, 9'h1FE, \
  9'h1FE, 9'h1F8, 9'h02A}
`endif

/* File: hw/cpe_pkg.sv */
// shared types and helper functions of the pixel path
`include "cpe_params.svh"
package cpe_pkg;
  typedef enum logic [2:0] {
    CPE_LS_OFF,
    CPE_LS_DAY,
    CPE_LS_TUNG,
    CPE_LS_COOL,
    CPE_LS_CUSTOM
  } cpe_light_t;
  typedef enum logic [1:0] {CPE_COL_R, CPE_COL_G, CPE_COL_B} cpe_col_t;
  typedef logic [8:0] cpe_gain_t;
  typedef logic [11:0] cpe_pix_t;

  function automatic cpe_pix_t fs_of(input logic [1:0] depth);
    if (depth == `CPE_D8) return `CPE_FS8;
    if (depth == `CPE_D10) return `CPE_FS10;
    return `CPE_FS12;
  endfunction

  function automatic cpe_pix_t clamp_fs(input logic signed [23:0] v,
                                        input cpe_pix_t fs);
    if (v < 0) return 12'h000;
    if (v > $signed({12'h000, fs})) return fs;
    return v[11:0];
  endfunction
endpackage

/* File: hw/cpe_line_mem.sv */
// one line of balanced pixels, read-before-write, registered read data
module cpe_line_mem #(
  parameter int W = 12,
  parameter int DEPTH = 2048
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // access
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] addr,
  input wire logic [W-1:0] wr_data,
  output logic [W-1:0] rd_data
);
  logic [W-1:0] mem_q [DEPTH];
  logic [W-1:0] rd_q;

  // the old word comes out, so the caller sees the line above
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) rd_q <= '0;
    else rd_q <= mem_q[addr];
  end

  always_ff @(posedge clk) begin
    if (wr_en) mem_q[addr] <= wr_data;
  end

  assign rd_data = rd_q;
endmodule

/* File: hw/cpe_tone_curve.sv */
// tone curve stage: display or user exponent curve, registered output
`include "cpe_params.svh"
module cpe_tone_curve (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // settings
  input wire logic enable,
  input wire logic user_kind,
  input wire logic [17:0] user_exp,
  input wire logic [1:0] depth,
  // pixel in
  input wire logic in_valid,
  input wire cpe_pkg::cpe_pix_t in_data,
  // pixel out
  output logic out_valid,
  output cpe_pkg::cpe_pix_t out_data
);
  function automatic logic [3:0] msb_of(input cpe_pkg::cpe_pix_t v);
    logic [3:0] p;
    p = 4'h0;
    for (int i = 0; i < 12; i++) if (v[i]) p = 4'(i);
    return p;
  endfunction

  logic valid_q;
  cpe_pkg::cpe_pix_t data_q;
  wire cpe_pkg::cpe_pix_t fs = cpe_pkg::fs_of(depth);
  wire logic [3:0] n = depth == `CPE_D8 ? 4'h8 :
                       depth == `CPE_D10 ? 4'hA : 4'hC;
  // display curve reuses the exponent path with 1/2.2
  wire logic [17:0] ex = user_kind ? user_exp : `CPE_GAM_SRGB;
  // log2 by leading one plus linear mantissa, exp2 is its exact inverse
  wire logic [3:0] e = msb_of(in_data);
  wire logic [10:0] man = 11'(in_data << (4'hB - e));
  wire logic [14:0] nlog = {4'(n - e), 11'h000} - {4'h0, man};
  wire logic [32:0] prod = nlog * ex;
  wire logic [5:0] ip = prod[32:27];
  wire logic [10:0] fp = prod[26:16];
  wire logic [24:0] y25 =
    ({12'h000, 13'h1000 - {2'b00, fp}} << n) >> ip >> 1;
  wire cpe_pkg::cpe_pix_t ycv = (y25[24:11] > {2'b00, fs}) ? fs : y25[22:11];
  wire cpe_pkg::cpe_pix_t curve =
    (in_data == 12'h000) ? 12'h000 :
    (in_data >= fs) ? fs :
    (ex == `CPE_GAM_ONE) ? in_data : ycv;
  wire cpe_pkg::cpe_pix_t nxt = enable ? curve : in_data;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      valid_q <= 1'b0;
      data_q <= 12'h000;
    end else begin
      valid_q <= in_valid;
      data_q <= nxt;
    end
  end

  assign out_valid = valid_q;
  assign out_data = data_q;

  property p_tone_bypass;
    @(posedge clk) disable iff (!reset_n)
    in_valid && !enable |=> out_valid && out_data == $past(in_data);
  endproperty
  a_tone_bypass: assert property (p_tone_bypass)
    else $error("disabled tone stage changed a pixel");

  property p_tone_unity;
    @(posedge clk) disable iff (!reset_n)
    in_valid && enable && user_kind && user_exp == `CPE_GAM_ONE
      |=> out_data == $past(in_data);
  endproperty
  a_tone_unity: assert property (p_tone_unity)
    else $error("unit exponent changed a pixel");

  property p_tone_black;
    @(posedge clk) disable iff (!reset_n)
    in_valid && enable && in_data == 12'h000 |=> out_data == 12'h000;
  endproperty
  a_tone_black: assert property (p_tone_black)
    else $error("black input not kept black");

  property p_tone_white;
    @(posedge clk) disable iff (!reset_n)
    in_valid && enable && in_data == fs |=> out_data == $past(fs);
  endproperty
  a_tone_white: assert property (p_tone_white)
    else $error("full scale input not kept at full scale");

  property p_tone_bound;
    @(posedge clk) disable iff (!reset_n)
    in_valid && enable ##1 out_valid |-> out_data <= $past(fs);
  endproperty
  a_tone_bound: assert property (p_tone_bound)
    else $error("tone output above full scale");
endmodule

/* File: hw/cpe_pixel_path.sv */
// colour enhancement pixel path: balance, colour matrix and tone curve
// Notes on behaviour
// - separate red, green, blue balance ratios, each on its own colour
// - ratio scales linearly, one is identity, range 0.00 to 15.984
// - first line is green-blue, second red-green; this fixes each colour
// - tone stage has an enable; disabled passes pixels unchanged
// - tone stage offers exactly two curves: display and user exponent
// - display curve is built in and needs no exponent
// - user curve: full scale times input ratio raised to the exponent
// - full scale is 255, 1023 or 4095 for 8, 10, 12 bit output
// - user exponent runs 0 to 3.99998; below one brightens
// - exponent one leaves brightness unchanged
// - zero stays zero and full scale stays full scale
// - matrix multiplies each pixel's red, green, blue vector
// - missing colours come from neighbours; only native result kept
// - conversion is RGB to RGB only, never another colour space
// - light source off passes pixels unaltered
// - daylight preset loads fixed coefficients for about 5000K
// - tungsten preset loads fixed coefficients for about 2500K-3000K
// - cool daylight preset loads fixed coefficients for about 6500K
// - custom preset uses nine coefficients written by software
// - strength 0 gives no matrix effect, 1 gives full effect
`include "cpe_params.svh"
module cpe_pixel_path #(
  parameter int LINE_MAX = 2048
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register port
  input wire logic [5:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // raw pixels from the sensor readout
  input wire logic pix_in_valid,
  input wire logic pix_in_sof,
  input wire logic pix_in_sol,
  input wire cpe_pkg::cpe_pix_t pix_in_data,
  // enhanced pixels to the output formatter
  output logic pix_out_valid,
  output cpe_pkg::cpe_pix_t pix_out_data
);
  localparam int AW = $clog2(LINE_MAX);

  generate
    if (LINE_MAX < 4 || LINE_MAX > 65536) begin : g_bad_line
      $error("LINE_MAX must lie between 4 and 65536");
    end
  endgenerate

  function automatic cpe_pkg::cpe_col_t col_of(input logic lp,
                                               input logic cp);
    if (!lp) return cp ? cpe_pkg::CPE_COL_B : cpe_pkg::CPE_COL_G;
    return cp ? cpe_pkg::CPE_COL_G : cpe_pkg::CPE_COL_R;
  endfunction

  // take the wanted colour from the 2x2 window ending at this pixel
  function automatic cpe_pkg::cpe_pix_t pick(
    input cpe_pkg::cpe_col_t want,
    input logic lp,
    input logic cp,
    input cpe_pkg::cpe_pix_t cur,
    input cpe_pkg::cpe_pix_t left,
    input cpe_pkg::cpe_pix_t up,
    input cpe_pkg::cpe_pix_t upleft);
    if (col_of(lp, cp) == want) return cur;
    if (col_of(lp, ~cp) == want) return left;
    if (col_of(~lp, cp) == want) return up;
    return upleft;
  endfunction

  function automatic cpe_pkg::cpe_gain_t preset_coef(input logic [2:0] ls,
                                                     input logic [3:0] k);
    logic [80:0] m;
    m = `CPE_MTX_DAY;
    if (ls == cpe_pkg::CPE_LS_TUNG) m = `CPE_MTX_TUNG;
    if (ls == cpe_pkg::CPE_LS_COOL) m = `CPE_MTX_COOL;
    return m[80 - 9 * k -: 9];
  endfunction

  // software settings
  logic gam_en_q;
  logic gam_user_q;
  logic [1:0] depth_q;
  logic [2:0] light_q;
  logic [9:0] bal_q [3];
  logic [17:0] gamma_q;
  logic [8:0] stren_q;
  cpe_pkg::cpe_gain_t gain_q [9];
  logic [31:0] rdata_q;
  logic [31:0] rd_mux;

  // pipeline state
  logic [AW-1:0] x_q;
  logic lp_q;
  logic v1_q;
  cpe_pkg::cpe_pix_t d1_q;
  logic [AW-1:0] x1_q;
  logic lp1_q;
  logic v2_q;
  cpe_pkg::cpe_pix_t d2_q;
  logic lp2_q;
  logic cp2_q;
  cpe_pkg::cpe_pix_t left_q;
  cpe_pkg::cpe_pix_t ul_q;
  logic v3_q;
  cpe_pkg::cpe_pix_t d3_q;
  cpe_pkg::cpe_pix_t up_w;

  // register decode
  wire logic wr_ctrl = reg_wr && reg_addr == `CPE_A_CTRL;
  wire logic wr_gamma = reg_wr && reg_addr == `CPE_A_GAMMA;
  wire logic wr_stren = reg_wr && reg_addr == `CPE_A_STREN;
  wire logic gain_hit = reg_addr >= `CPE_A_GAIN0 &&
                        reg_addr <= `CPE_A_GAIN8 && reg_addr[1:0] == 2'h0;
  wire logic [3:0] gidx = 4'((reg_addr - `CPE_A_GAIN0) >> 2);
  wire logic custom = light_q == cpe_pkg::CPE_LS_CUSTOM;
  wire cpe_pkg::cpe_pix_t fs = cpe_pkg::fs_of(depth_q);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gam_en_q <= 1'b0;
      gam_user_q <= 1'b0;
      depth_q <= `CPE_D12;
      light_q <= cpe_pkg::CPE_LS_OFF;
    end else if (wr_ctrl) begin
      gam_en_q <= reg_wdata[`CPE_F_GEN];
      gam_user_q <= reg_wdata[`CPE_F_GUSER];
      depth_q <= reg_wdata[`CPE_F_DEPTH];
      // unknown light source codes fall back to off
      light_q <= reg_wdata[`CPE_F_LIGHT] > 3'(cpe_pkg::CPE_LS_CUSTOM) ?
                 cpe_pkg::CPE_LS_OFF : reg_wdata[`CPE_F_LIGHT];
    end
  end

  // 2.16 exponent: 18 bits cover 0 to 3.99998 exactly
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) gamma_q <= `CPE_GAM_ONE;
    else if (wr_gamma) gamma_q <= reg_wdata[17:0];
  end

  // strength above one saturates so the blend never extrapolates
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) stren_q <= `CPE_STREN_ONE;
    else if (wr_stren) stren_q <= reg_wdata[15:0] > 16'(`CPE_STREN_ONE) ?
                                  `CPE_STREN_ONE : reg_wdata[8:0];
  end

  // 4.6 ratio: 10 bits span 0.00 to 15.984
  for (genvar c = 0; c < 3; c++) begin : g_bal
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) bal_q[c] <= `CPE_BAL_ONE;
      else if (reg_wr && reg_addr == `CPE_A_BAL0 + 6'(4 * c))
        bal_q[c] <= reg_wdata[9:0];
    end
  end

  // custom matrix resets to identity
  for (genvar g = 0; g < 9; g++) begin : g_gain
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
        gain_q[g] <= (g % 4 == 0) ? `CPE_GAIN_ONE : 9'h000;
      else if (reg_wr && reg_addr == `CPE_A_GAIN0 + 6'(4 * g))
        gain_q[g] <= reg_wdata[8:0];
    end
  end

  // conversion type field always reads as RGB to RGB (zero)
  always_comb begin
    rd_mux = 32'h0;
    case (reg_addr)
      `CPE_A_CTRL: rd_mux = 32'({1'b0, light_q, depth_q, gam_user_q,
                                 gam_en_q});
      `CPE_A_BAL0: rd_mux = 32'(bal_q[0]);
      `CPE_A_BAL0 + 6'h04: rd_mux = 32'(bal_q[1]);
      `CPE_A_BAL0 + 6'h08: rd_mux = 32'(bal_q[2]);
      `CPE_A_GAMMA: rd_mux = 32'(gamma_q);
      `CPE_A_STREN: rd_mux = 32'(stren_q);
      `CPE_A_STAT: rd_mux = {15'h0, lp_q, 16'(x_q)};
      default: if (gain_hit) rd_mux = 32'(gain_q[gidx]);
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) rdata_q <= 32'h0;
    else rdata_q <= reg_rd ? rd_mux : 32'h0;
  end

  assign reg_rdata = rdata_q;

  // stage 0: position in the frame and colour of the arriving pixel
  wire logic lead = pix_in_sof | pix_in_sol;
  wire logic [AW-1:0] x0 = lead ? '0 : x_q + 1'b1;
  wire logic lp0 = pix_in_sof ? 1'b0 : (pix_in_sol ? ~lp_q : lp_q);
  wire cpe_pkg::cpe_col_t c0 = col_of(lp0, x0[0]);

  // balance scaling, one ratio per colour
  wire logic [9:0] bal_sel = bal_q[c0];
  wire logic [21:0] bprod = pix_in_data * bal_sel;
  wire cpe_pkg::cpe_pix_t bal_out =
    cpe_pkg::clamp_fs($signed({2'b00, bprod}) >>> `CPE_BAL_FRAC, fs);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      x_q <= '0;
      lp_q <= 1'b0;
    end else if (pix_in_valid) begin
      x_q <= x0;
      lp_q <= lp0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      v1_q <= 1'b0;
      d1_q <= 12'h000;
      x1_q <= '0;
      lp1_q <= 1'b0;
    end else begin
      v1_q <= pix_in_valid;
      d1_q <= bal_out;
      x1_q <= x0;
      lp1_q <= lp0;
    end
  end

  // the line store hands back the pixel above while the new one goes in
  cpe_line_mem #(
    .W(12),
    .DEPTH(LINE_MAX)
  ) u_line (
    .clk(clk),
    .reset_n(reset_n),
    .wr_en(v1_q),
    .addr(x1_q),
    .wr_data(d1_q),
    .rd_data(up_w)
  );

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      v2_q <= 1'b0;
      d2_q <= 12'h000;
      lp2_q <= 1'b0;
      cp2_q <= 1'b0;
    end else begin
      v2_q <= v1_q;
      d2_q <= d1_q;
      lp2_q <= lp1_q;
      cp2_q <= x1_q[0];
    end
  end

  // left and upper-left neighbours; at line start they still hold the
  // previous line's end, a known edge artefact of a one-line window
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      left_q <= 12'h000;
      ul_q <= 12'h000;
    end else if (v2_q) begin
      left_q <= d2_q;
      ul_q <= up_w;
    end
  end

  // stage 2: fill the vector and keep only the native row
  wire cpe_pkg::cpe_col_t c2 = col_of(lp2_q, cp2_q);
  wire cpe_pkg::cpe_pix_t vr =
    pick(cpe_pkg::CPE_COL_R, lp2_q, cp2_q, d2_q, left_q, up_w, ul_q);
  wire cpe_pkg::cpe_pix_t vg =
    pick(cpe_pkg::CPE_COL_G, lp2_q, cp2_q, d2_q, left_q, up_w, ul_q);
  wire cpe_pkg::cpe_pix_t vb =
    pick(cpe_pkg::CPE_COL_B, lp2_q, cp2_q, d2_q, left_q, up_w, ul_q);
  wire logic [3:0] row = 4'(3 * c2);
  cpe_pkg::cpe_gain_t cf [3];

  for (genvar k = 0; k < 3; k++) begin : g_coef
    assign cf[k] = custom ? gain_q[row + 4'(k)]
                 : preset_coef(light_q, row + 4'(k));
  end

  wire logic signed [23:0] acc =
    $signed({1'b0, vr}) * $signed(cf[0]) +
    $signed({1'b0, vg}) * $signed(cf[1]) +
    $signed({1'b0, vb}) * $signed(cf[2]);
  wire logic signed [23:0] mtx = acc >>> `CPE_GAIN_FRAC;
  wire logic signed [23:0] cur = $signed({12'h000, d2_q});
  wire logic signed [23:0] diff = mtx - cur;
  wire logic signed [33:0] wtd = diff * $signed({1'b0, stren_q});
  wire logic signed [23:0] blend =
    cur + 24'(wtd >>> `CPE_STREN_FRAC);
  wire cpe_pkg::cpe_pix_t mtx_out =
    (light_q == cpe_pkg::CPE_LS_OFF) ? d2_q :
    cpe_pkg::clamp_fs(blend, fs);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      v3_q <= 1'b0;
      d3_q <= 12'h000;
    end else begin
      v3_q <= v2_q;
      d3_q <= mtx_out;
    end
  end

  // stage 3: tone curve, last in the chain
  cpe_tone_curve u_tone (
    .clk(clk),
    .reset_n(reset_n),
    .enable(gam_en_q),
    .user_kind(gam_user_q),
    .user_exp(gamma_q),
    .depth(depth_q),
    .in_valid(v3_q),
    .in_data(d3_q),
    .out_valid(pix_out_valid),
    .out_data(pix_out_data)
  );

  property p_latency;
    @(posedge clk) disable iff (!reset_n)
    pix_in_valid |-> ##4 pix_out_valid;
  endproperty
  a_latency: assert property (p_latency)
    else $error("pixel did not leave four cycles after entry");

  property p_first_green;
    @(posedge clk) disable iff (!reset_n)
    pix_in_valid && pix_in_sof |-> c0 == cpe_pkg::CPE_COL_G;
  endproperty
  a_first_green: assert property (p_first_green)
    else $error("first pixel of frame not green");

  property p_second_red;
    @(posedge clk) disable iff (!reset_n)
    pix_in_valid && pix_in_sol && !pix_in_sof && !lp_q
      |-> c0 == cpe_pkg::CPE_COL_R;
  endproperty
  a_second_red: assert property (p_second_red)
    else $error("first pixel of odd line not red");

  property p_bal_unity;
    @(posedge clk) disable iff (!reset_n)
    pix_in_valid && bal_sel == `CPE_BAL_ONE && pix_in_data <= fs
      |=> v1_q && d1_q == $past(pix_in_data);
  endproperty
  a_bal_unity: assert property (p_bal_unity)
    else $error("unit balance ratio changed a pixel");

  property p_light_off;
    @(posedge clk) disable iff (!reset_n)
    v2_q && light_q == cpe_pkg::CPE_LS_OFF |=> d3_q == $past(d2_q);
  endproperty
  a_light_off: assert property (p_light_off)
    else $error("matrix altered pixel with light source off");

  property p_stren_zero;
    @(posedge clk) disable iff (!reset_n)
    v2_q && stren_q == 9'h000 && d2_q <= fs |=> d3_q == $past(d2_q);
  endproperty
  a_stren_zero: assert property (p_stren_zero)
    else $error("zero strength still changed a pixel");

  property p_custom_coef;
    @(posedge clk) disable iff (!reset_n)
    v2_q && custom |-> cf[0] == gain_q[row] && cf[2] == gain_q[row + 4'h2];
  endproperty
  a_custom_coef: assert property (p_custom_coef)
    else $error("custom mode not using software coefficients");
endmodule

/* File: tb/cpe_sensor_model.sv */
// sensor readout model: plays one 2-line by 4-pixel raw frame per go pulse
module cpe_sensor_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // control from the bench
  input wire logic go,
  input wire logic gap,
  input wire logic [11:0] value,
  output logic busy,
  // raw pixel stream
  output logic pix_valid,
  output logic sof,
  output logic sol,
  output logic [11:0] data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] pos_q;
  logic idle_q;

  // between pixels the data lines flip, so a stale value never looks valid
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy <= 1'b0;
      pos_q <= 3'h0;
      idle_q <= 1'b0;
      pix_valid <= 1'b0;
      sof <= 1'b0;
      sol <= 1'b0;
      data <= 12'h000;
    end else if (busy && !idle_q) begin
      pix_valid <= 1'b1;
      sof <= (pos_q == 3'h0);
      sol <= (pos_q[1:0] == 2'h0);
      data <= value;
      pos_q <= pos_q + 3'h1;
      idle_q <= gap;
      busy <= (pos_q != 3'h7);
    end else begin
      pix_valid <= 1'b0;
      sof <= 1'b0;
      sol <= 1'b0;
      data <= ~data;
      idle_q <= 1'b0;
      if (go && !busy) begin
        busy <= 1'b1;
        pos_q <= 3'h0;
      end
    end
  end
endmodule

/* File: tb/testbench.sv */
// self-checking bench of the colour enhancement pixel path
`define CHK(G, X) check_val(32'(G), 32'(X))
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [7:0] ctrl;
    logic [9:0] br, bg, bb;
    logic [17:0] gam;
    logic [8:0] st;
    logic [11:0] v, er, eg, eb;
  } cpe_row_t;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic pix_in_valid, pix_in_sof, pix_in_sol, pix_out_valid, busy;
  cpe_pkg::cpe_pix_t pix_in_data, pix_out_data;
  logic go = 1'b0;
  logic gap = 1'b0;
  logic [11:0] value = 12'h000;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [12:0] eq[$];
  int tq[$];
  cpe_row_t rows[12];
  logic [5:0] ra[8] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14, 6'h18,
                        6'h1C};
  logic [31:0] rv[8] = '{32'h8, 32'h40, 32'h40, 32'h40, 32'h10000, 32'h100,
                         32'h20, 32'h0};

  cpe_pixel_path #(.LINE_MAX(16)) u_dut (.clk(clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pix_in_valid(pix_in_valid),
    .pix_in_sof(pix_in_sof), .pix_in_sol(pix_in_sol),
    .pix_in_data(pix_in_data), .pix_out_valid(pix_out_valid),
    .pix_out_data(pix_out_data));
  cpe_sensor_model u_src (.clk(clk), .reset_n(reset_n), .go(go), .gap(gap),
    .value(value), .busy(busy), .pix_valid(pix_in_valid), .sof(pix_in_sof),
    .sol(pix_in_sol), .data(pix_in_data));

  initial begin
    forever #25 clk = ~clk;
  end

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (bad_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand one cycle only, so the cycle after is checked for zero
  task automatic rd(input logic [5:0] a, input logic [31:0] x);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    `CHK(reg_rdata, x);
    @(posedge clk);
    `CHK(reg_rdata, 32'h0);
  endtask

  task automatic setup(input cpe_row_t r);
    wr(6'h00, 32'(r.ctrl));
    wr(6'h04, 32'(r.br));
    wr(6'h08, 32'(r.bg));
    wr(6'h0C, 32'(r.bb));
    wr(6'h10, 32'(r.gam));
    wr(6'h14, 32'(r.st));
  endtask

  // bit 12 of an expectation asks only for a brighter, unsaturated output
  task automatic play(input logic [11:0] v, input logic g,
                      input logic [12:0] er, eg, eb);
    for (int p = 0; p < 8; p++) begin
      eq.push_back(p[2] ? (p[0] ? eg : er) : (p[0] ? eb : eg));
    end
    @(posedge clk);
    go <= 1'b1;
    value <= v;
    gap <= g;
    @(posedge clk);
    go <= 1'b0;
    repeat (40) begin
      @(posedge clk);
      if (busy === 1'b0) break;
    end
    repeat (8) @(posedge clk);
    `CHK(eq.size(), 0);
  endtask

  task automatic check_out();
    logic [12:0] e;
    int t;
    `CHK(eq.size() != 0, 1'b1);
    if (eq.size() != 0) begin
      e = eq.pop_front();
      t = tq.pop_front();
      `CHK(cyc - t, 4);
      if (e[12]) begin
        `CHK(pix_out_data > e[11:0] && pix_out_data < 12'hFFF, 1'b1);
      end else begin
        `CHK(pix_out_data, e[11:0]);
      end
    end
  endtask

  always @(posedge clk) begin
    cyc++;
    if (pix_in_valid === 1'b1) tq.push_back(cyc);
    if (pix_out_valid === 1'b1) check_out();
  end

  initial begin
    rows[0] = '{8'h08, 10'h080, 10'h040, 10'h020, 18'h10000, 9'h100,
                12'h100, 12'h200, 12'h100, 12'h080};
    rows[1] = '{8'h00, 10'h080, 10'h080, 10'h080, 18'h10000, 9'h100,
                12'h0F0, 12'h0FF, 12'h0FF, 12'h0FF};
    rows[2] = '{8'h07, 10'h040, 10'h040, 10'h040, 18'h10000, 9'h100,
                12'h123, 12'h123, 12'h123, 12'h123};
    rows[3] = '{8'h0B, 10'h040, 10'h040, 10'h040, 18'h20000, 9'h100,
                12'h000, 12'h000, 12'h000, 12'h000};
    rows[4] = '{8'h0F, 10'h040, 10'h040, 10'h040, 18'h20000, 9'h100,
                12'hFFF, 12'hFFF, 12'hFFF, 12'hFFF};
    rows[5] = '{8'h03, 10'h040, 10'h040, 10'h040, 18'h20000, 9'h100,
                12'h0FF, 12'h0FF, 12'h0FF, 12'h0FF};
    rows[6] = '{8'h0A, 10'h040, 10'h040, 10'h040, 18'h20000, 9'h100,
                12'h400, 12'h400, 12'h400, 12'h400};
    rows[7] = '{8'h0B, 10'h040, 10'h040, 10'h040, 18'h00000, 9'h100,
                12'h010, 12'hFFF, 12'hFFF, 12'hFFF};
    rows[8] = '{8'h18, 10'h040, 10'h040, 10'h040, 18'h10000, 9'h000,
                12'h345, 12'h345, 12'h345, 12'h345};
    rows[9] = '{8'h28, 10'h040, 10'h040, 10'h040, 18'h10000, 9'h000,
                12'h345, 12'h345, 12'h345, 12'h345};
    rows[10] = '{8'h38, 10'h040, 10'h040, 10'h040, 18'h10000, 9'h000,
                 12'h345, 12'h345, 12'h345, 12'h345};
    rows[11] = '{8'h09, 10'h040, 10'h040, 10'h040, 18'h10000, 9'h100,
                 12'hFFF, 12'hFFF, 12'hFFF, 12'hFFF};
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    foreach (rows[i]) begin
      setup(rows[i]);
      play(rows[i].v, i[0], {1'b0, rows[i].er}, {1'b0, rows[i].eg},
           {1'b0, rows[i].eb});
    end
    // custom matrix doubles red; later red also adds its green neighbour
    setup('{8'h48, 10'h040, 10'h040, 10'h040, 18'h10000, 9'h080,
            12'h0, 12'h0, 12'h0, 12'h0});
    wr(6'h18, 32'h40);
    play(12'h200, 1'b0, 13'h0300, 13'h0200, 13'h0200);
    wr(6'h14, 32'h100);
    wr(6'h1C, 32'h20);
    play(12'h200, 1'b1, 13'h0600, 13'h0200, 13'h0200);
    play(12'hC00, 1'b0, 13'h0FFF, 13'h0C00, 13'h0C00);
    wr(6'h00, 32'h08);
    play(12'h200, 1'b0, 13'h0200, 13'h0200, 13'h0200);
    wr(6'h00, 32'h09);
    play(12'h400, 1'b0, 13'h1400, 13'h1400, 13'h1400);
    wr(6'h14, 32'h1FF);
    rd(6'h14, 32'h100);
    wr(6'h00, 32'hD8);
    rd(6'h00, 32'h08);
    rd(6'h02, 32'h0);
    rd(6'h3C, 32'h10003);
    // second reset in mid-run brings back every setting
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    foreach (ra[i]) rd(ra[i], rv[i]);
    tally_and_finish();
  end

  // the whole sequence needs about 600 cycles
  initial begin
    #(20000 * 50);
    bad_count++;
    tally_and_finish();
  end
endmodule
